// >>> common/pmm_defines.svh
`ifndef PMM_DEFINES_SVH
`define PMM_DEFINES_SVH
// Register byte addresses
`define PMM_ADDR_ACT_TPL   12'h000
`define PMM_ADDR_ALT_TPL   12'h004
`define PMM_ADDR_MODE_REQ  12'h008
`define PMM_ADDR_WAKE_EN   12'h00c
`define PMM_ADDR_BOOST     12'h010
`define PMM_ADDR_CTW       12'h014
`define PMM_ADDR_STATUS    12'h018
`define PMM_ADDR_WAKE_SRC  12'h01c
// Mode request codes
`define PMM_REQ_ACTIVE     2'h0
`define PMM_REQ_ALT        2'h1
`define PMM_REQ_SLEEP      2'h2
`define PMM_REQ_HIBERNATE  2'h3
// Template layout, bit 0 is the CPU
`define PMM_CPU_BIT        0
`define PMM_TPL_RESET      8'hff
`define PMM_ALT_RESET      8'hfe
// Wake enable bits
`define PMM_WK_PERIPH      0
`define PMM_WK_SUPERV      1
`define PMM_WK_CTW         2
`define PMM_WK_PIN         3
`define PMM_WK_RESET       4'hf
// Synchroniser idle levels, every source inactive
`define PMM_SYNC_IDLE      6'h07
// Resume times and clock period in ns, then timewheel reset period
`define PMM_SLEEP_RESUME_NS 15000
`define PMM_HIB_RESUME_NS   100000
`define PMM_CLK_NS          4
`define PMM_CTW_RESET       32'h0000_ffff
`endif

// >>> common/pmm_pkg.sv
`default_nettype none
package pmm_pkg;
	typedef enum logic [2:0] {
		PMM_ACTIVE,
		PMM_ALT_ACTIVE,
		PMM_SLEEP,
		PMM_HIBERNATE,
		PMM_RESUME
	} pmm_state_t;
endpackage : pmm_pkg
`default_nettype wire

// >>> core/pmm_power_mode_manager.sv
// What this block does
// [R1] Active mode applies active template bits
// [R2] Disabled subsystem has its clock gated
// [R3] Firmware may change templates any time
// [R4] CPU may disable itself, wakeup restores
// [R5] Wakeup forces active mode, CPU on
// [R6] Active mode after reset
// [R7] Alternate active uses smaller alternate template
// [R8] Sleep exit waits 15 us resume
// [R9] Hibernate disables functions, keeps state
// [R10] Hibernate holds outputs and pin settings
// [R11] Hibernate exits on pin interrupt, under 100 us
// [R12] Pins toggle no faster than 10 kHz, not limited or checked by this block
// [R13] Separately enabled wakeup interrupt sources
// [R14] Central timewheel raises periodic interrupts
// [R15] Reset sources act as wakeup events
// [R16] Boost has active and standby modes
// [R17] Boost active in active modes
// [R18] Sleep allows boost standby with refresh
// [R19] Hibernate allows only boost active
// [R20] Sleep disables most resources regardless
// [R21] Only known firmware mode requests leave active
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pmm_defines.svh"
module pmm_power_mode_manager #(
	parameter int NSUB         = 8,
	parameter int SLEEP_CYCLES = (`PMM_SLEEP_RESUME_NS + `PMM_CLK_NS - 1)
	                             / `PMM_CLK_NS,
	// Margin for pin sync and enable register keeps exit under limit
	parameter int HIB_CYCLES   = `PMM_HIB_RESUME_NS / `PMM_CLK_NS - 5
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             clkEn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output var  logic [31:0]      prdata,
	output var  logic             pready,
	output var  logic             pslverr,
	input  wire logic             periphIrq,
	input  wire logic             supervisorIrq,
	input  wire logic             pinIrq,
	input  wire logic             external_reset_pin,
	input  wire logic             watchdog_reset_source,
	input  wire logic             precise_low_voltage_reset,
	input  wire logic [NSUB-1:0]  subClkIn,
	output var  logic [NSUB-1:0]  subEnable,
	output var  logic [NSUB-1:0]  subClkOut,
	output var  logic             stateHold,
	output var  logic             boostStandby,
	output var  logic             ctwIrq,
	output var  logic [2:0]       globalMode
);
	// ==========================================================
	// Input synchronisers
	// ==========================================================
	logic [5:0] syncA;
	logic [5:0] syncB;
	logic       periphS;
	logic       supervS;
	logic       pinS;
	logic       xresS;
	logic       wdtS;
	logic       presS;

	// Two stages for every outside level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			syncA <= `PMM_SYNC_IDLE;
			syncB <= `PMM_SYNC_IDLE;
		end else if (clkEn) begin
			syncA <= {periphIrq, supervisorIrq, pinIrq,
			          external_reset_pin, ~watchdog_reset_source,
			          ~precise_low_voltage_reset};
			syncB <= syncA;
		end
	end
	assign periphS = syncB[5];
	assign supervS = syncB[4];
	assign pinS    = syncB[3];
	assign xresS   = ~syncB[2];
	assign wdtS    = ~syncB[1];
	assign presS   = ~syncB[0];

	// ==========================================================
	// Registers
	// ==========================================================
	pmm_pkg::pmm_state_t state;
	pmm_pkg::pmm_state_t next_state;
	logic [NSUB-1:0] actTpl;
	logic [NSUB-1:0] altTpl;
	logic [3:0]      wakeEn;
	logic            boostStbyReq;
	logic [31:0]     ctwPeriod;
	logic [31:0]     ctwCount;
	logic [4:0]      wakeSrc;
	logic            cpuForce;
	logic [31:0]     resumeCnt;
	logic [1:0]      reqMode;
	logic            reqValid;
	logic            wrStb;
	logic            rdStb;
	logic            resetWake;
	logic            irqWake;
	logic            wake;
	logic [4:0]      wakeNow;

	// Address decode of the mapped registers
	function automatic logic decodeOk(input logic [11:0] a);
		decodeOk = (a == `PMM_ADDR_ACT_TPL) || (a == `PMM_ADDR_ALT_TPL)
			|| (a == `PMM_ADDR_MODE_REQ) || (a == `PMM_ADDR_WAKE_EN)
			|| (a == `PMM_ADDR_BOOST) || (a == `PMM_ADDR_CTW)
			|| (a == `PMM_ADDR_STATUS) || (a == `PMM_ADDR_WAKE_SRC);
	endfunction : decodeOk

	// Zero-wait APB, write taken in access phase
	assign pready  = 1'b1;
	assign wrStb   = psel && penable && pwrite && clkEn;
	assign rdStb   = psel && penable && !pwrite;
	assign pslverr = psel && penable && !decodeOk(paddr);

	// Template registers, writable in any mode
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			actTpl <= NSUB'(`PMM_TPL_RESET);
			altTpl <= NSUB'(`PMM_ALT_RESET);
		end else if (wrStb) begin
			if (paddr == `PMM_ADDR_ACT_TPL)
				actTpl <= pwdata[NSUB-1:0]; // [R3]
			if (paddr == `PMM_ADDR_ALT_TPL)
				altTpl <= pwdata[NSUB-1:0]; // [R3]
		end
	end

	// Wake enables, boost and timewheel settings
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wakeEn       <= `PMM_WK_RESET;
			boostStbyReq <= 1'b0;
			ctwPeriod    <= `PMM_CTW_RESET;
		end else if (wrStb) begin
			if (paddr == `PMM_ADDR_WAKE_EN)
				wakeEn <= pwdata[3:0]; // [R13]
			if (paddr == `PMM_ADDR_BOOST)
				boostStbyReq <= pwdata[0];
			if (paddr == `PMM_ADDR_CTW)
				ctwPeriod <= pwdata;
		end
	end

	// Mode request decode
	assign reqMode  = pwdata[1:0];
	assign reqValid = wrStb && (paddr == `PMM_ADDR_MODE_REQ)
		&& (pwdata[31:2] == 30'h0); // [R21]

	// Read mux
	always_comb begin
		prdata = 32'h0;
		if (rdStb) begin
			unique case (paddr)
				`PMM_ADDR_ACT_TPL:  prdata = 32'(actTpl);
				`PMM_ADDR_ALT_TPL:  prdata = 32'(altTpl);
				`PMM_ADDR_MODE_REQ: prdata = 32'(globalMode);
				`PMM_ADDR_WAKE_EN:  prdata = 32'(wakeEn);
				`PMM_ADDR_BOOST:    prdata = {31'h0, boostStbyReq};
				`PMM_ADDR_CTW:      prdata = ctwPeriod;
				`PMM_ADDR_STATUS:   prdata = {28'h0, cpuForce, globalMode};
				`PMM_ADDR_WAKE_SRC: prdata = 32'(wakeSrc);
				default:            prdata = 32'h0;
			endcase
		end
	end

	// ==========================================================
	// Central timewheel
	// ==========================================================
	// Periodic pulse, runs in every mode but hibernate
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctwCount <= 32'h0;
			ctwIrq   <= 1'b0;
		end else if (clkEn) begin
			ctwIrq <= 1'b0;
			if (state == pmm_pkg::PMM_HIBERNATE) begin
				ctwCount <= 32'h0;
			end else if (ctwCount >= ctwPeriod) begin
				ctwCount <= 32'h0;
				ctwIrq   <= 1'b1; // [R14]
			end else begin
				ctwCount <= ctwCount + 32'h1;
			end
		end
	end

	// ==========================================================
	// Wakeup events
	// ==========================================================
	assign resetWake = xresS || wdtS || presS; // [R15]
	assign wakeNow = {resetWake,
		pinS && wakeEn[`PMM_WK_PIN],
		ctwIrq && wakeEn[`PMM_WK_CTW],
		supervS && wakeEn[`PMM_WK_SUPERV],
		periphS && wakeEn[`PMM_WK_PERIPH]}; // [R13]
	always_comb begin
		irqWake = 1'b0;
		unique case (state)
			pmm_pkg::PMM_HIBERNATE: irqWake = wakeNow[3]; // [R11]
			default:                irqWake = |wakeNow[3:0];
		endcase
	end
	assign wake = irqWake || resetWake;

	// Latch which sources woke the device, cleared by reading
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wakeSrc <= 5'h0;
		end else if (clkEn) begin
			if (wake && state != pmm_pkg::PMM_RESUME)
				wakeSrc <= wakeSrc | wakeNow; // Set beats clear
			else if (rdStb && paddr == `PMM_ADDR_WAKE_SRC)
				wakeSrc <= 5'h0;
		end
	end

	// ==========================================================
	// Mode state machine
	// ==========================================================
	always_comb begin
		next_state = state;
		unique case (state)
			pmm_pkg::PMM_ACTIVE, pmm_pkg::PMM_ALT_ACTIVE: begin
				if (resetWake)
					next_state = pmm_pkg::PMM_ACTIVE; // [R15]
				else if (state == pmm_pkg::PMM_ALT_ACTIVE && irqWake)
					next_state = pmm_pkg::PMM_ACTIVE; // [R5]
				else if (reqValid) begin
					unique case (reqMode)
						`PMM_REQ_ACTIVE:    next_state = pmm_pkg::PMM_ACTIVE;
						`PMM_REQ_ALT:       next_state = pmm_pkg::PMM_ALT_ACTIVE;
						`PMM_REQ_SLEEP:     next_state = pmm_pkg::PMM_SLEEP;
						`PMM_REQ_HIBERNATE: next_state = pmm_pkg::PMM_HIBERNATE;
					endcase // [R21]
				end
			end
			pmm_pkg::PMM_SLEEP, pmm_pkg::PMM_HIBERNATE: begin
				if (wake)
					next_state = pmm_pkg::PMM_RESUME; // [R8] [R11]
			end
			pmm_pkg::PMM_RESUME: begin
				if (resumeCnt == 32'h0)
					next_state = pmm_pkg::PMM_ACTIVE; // [R8]
			end
			default: next_state = pmm_pkg::PMM_ACTIVE;
		endcase
	end

	// State register, active after reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			state <= pmm_pkg::PMM_ACTIVE; // [R6]
		else if (clkEn)
			state <= next_state;
	end

	// Resume counter, length picked by the mode left
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			resumeCnt <= 32'h0;
		end else if (clkEn) begin
			if (state == pmm_pkg::PMM_SLEEP && wake)
				resumeCnt <= 32'(SLEEP_CYCLES - 1); // [R8]
			else if (state == pmm_pkg::PMM_HIBERNATE && wake)
				resumeCnt <= 32'(HIB_CYCLES - 1); // [R11]
			else if (resumeCnt != 32'h0)
				resumeCnt <= resumeCnt - 32'h1;
		end
	end

	// CPU forced on from any wakeup until firmware rewrites
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cpuForce <= 1'b0;
		end else if (clkEn) begin
			if (wake && next_state != state
					&& next_state != pmm_pkg::PMM_HIBERNATE)
				cpuForce <= 1'b1; // [R4] [R5]
			else if (wake && state == pmm_pkg::PMM_ACTIVE)
				cpuForce <= 1'b1; // [R5]
			else if (wrStb && paddr == `PMM_ADDR_ACT_TPL)
				cpuForce <= 1'b0; // [R4]
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Enables per mode, registered
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			subEnable <= NSUB'(`PMM_TPL_RESET);
		end else if (clkEn) begin
			unique case (state)
				pmm_pkg::PMM_ACTIVE: begin
					subEnable <= actTpl; // [R1]
					subEnable[`PMM_CPU_BIT] <= actTpl[`PMM_CPU_BIT]
						| cpuForce; // [R4]
				end
				pmm_pkg::PMM_ALT_ACTIVE:
					subEnable <= altTpl; // [R7]
				default:
					subEnable <= '0; // [R9] [R20]
			endcase
		end
	end

	// Clock gating of disabled subsystems
	assign subClkOut = subClkIn & subEnable; // [R2]

	// Hold outputs, config and pin interrupt setup in hibernate
	assign stateHold = (state == pmm_pkg::PMM_HIBERNATE); // [R9] [R10]

	// Standby allowed only in sleep
	assign boostStandby = (state == pmm_pkg::PMM_SLEEP)
		&& boostStbyReq; // [R16] [R17] [R18] [R19]

	assign globalMode = 3'(state);

	// ==========================================================
	// Checks
	// ==========================================================
	chk_boost_active_modes: assert property (@(posedge clk) // [R17]
		disable iff (!resetn)
		(state != pmm_pkg::PMM_SLEEP) |-> !boostStandby)
		else $error("boost standby outside sleep");

	chk_sleep_resume_len: assert property (@(posedge clk) // [R8]
		disable iff (!resetn)
		(clkEn && state == pmm_pkg::PMM_SLEEP && wake) |=>
		(state == pmm_pkg::PMM_RESUME && resumeCnt == 32'(SLEEP_CYCLES - 1)))
		else $error("sleep resume count wrong");

	chk_reset_wakes: assert property (@(posedge clk) // [R15]
		disable iff (!resetn)
		(clkEn && resetWake && (state == pmm_pkg::PMM_ACTIVE
			|| state == pmm_pkg::PMM_ALT_ACTIVE)) |=>
		state == pmm_pkg::PMM_ACTIVE)
		else $error("reset source did not return to active");

	chk_hib_pin_only: assert property (@(posedge clk) // [R11]
		disable iff (!resetn)
		(clkEn && state == pmm_pkg::PMM_HIBERNATE && !wakeNow[3]
			&& !resetWake) |=> state == pmm_pkg::PMM_HIBERNATE)
		else $error("hibernate left without pin wake");

	chk_sleep_gated: assert property (@(posedge clk) // [R20]
		disable iff (!resetn)
		(clkEn && state == pmm_pkg::PMM_SLEEP) |=> subEnable == '0)
		else $error("resources enabled in sleep");

	chk_active_template: assert property (@(posedge clk) // [R1]
		disable iff (!resetn)
		(clkEn && state == pmm_pkg::PMM_ACTIVE && !cpuForce) |=>
		subEnable == $past(actTpl))
		else $error("active enables differ from template");

	chk_alt_template: assert property (@(posedge clk) // [R7]
		disable iff (!resetn)
		(clkEn && state == pmm_pkg::PMM_ALT_ACTIVE) |=>
		subEnable == $past(altTpl))
		else $error("alternate enables differ from template");

	chk_bad_req_ignored: assert property (@(posedge clk) // [R21]
		disable iff (!resetn)
		(clkEn && state == pmm_pkg::PMM_ACTIVE && wrStb && !resetWake
			&& paddr == `PMM_ADDR_MODE_REQ && pwdata[31:2] != 30'h0)
		|=> state == pmm_pkg::PMM_ACTIVE)
		else $error("unknown mode request acted on");

	chk_clock_gate: assert property (@(posedge clk) // [R2]
		disable iff (!resetn)
		!subEnable[0] |-> !subClkOut[0])
		else $error("disabled subsystem clock running");

	chk_cpu_on_wake: assert property (@(posedge clk) // [R5]
		disable iff (!resetn)
		(clkEn && state == pmm_pkg::PMM_RESUME && resumeCnt == 32'h0)
		|=> cpuForce ##1 subEnable[`PMM_CPU_BIT] || !clkEn)
		else $error("cpu not enabled after wake");
endmodule : pmm_power_mode_manager
`default_nettype wire

// >>> bench/pmm_wake_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmm_wake_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [5:0] fire,
	output var  logic       periphIrq,
	output var  logic       supervisorIrq,
	output var  logic       pinIrq,
	output var  logic       external_reset_pin,
	output var  logic       watchdog_reset_source,
	output var  logic       precise_low_voltage_reset,
	output var  logic [7:0] subClkIn
);
	logic [5:0] act;
	logic [4:0] cnt;
	// ==========================================
	// Sources
	// Hold a source seven cycles, a pin long past hibernate exit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			act <= 6'h00;
			cnt <= 5'h00;
		end else if (fire != 6'h00) begin
			act <= fire;
			cnt <= fire[2] ? 5'h1f : 5'h06;
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
		end else begin
			act <= 6'h00;
		end
	end
	// Interrupt levels, active high
	assign periphIrq                 = act[0];
	assign supervisorIrq             = act[1];
	assign pinIrq                    = act[2];
	// Reset sources, pin active low
	assign external_reset_pin        = ~act[3];
	assign watchdog_reset_source     = act[4];
	assign precise_low_voltage_reset = act[5];
	// Subsystem clocks at assorted rates
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			subClkIn <= 8'h00;
		end else begin
			subClkIn <= subClkIn + 8'h01;
		end
	end
endmodule : pmm_wake_model
`default_nettype wire

// >>> bench/pmm_power_mode_manager_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "pmm_defines.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
	error_cnt++; $display("Error %s exp %0h got %0h", nm, ex, got); end end
module pmm_power_mode_manager_bench;
	logic        clk, resetn, clkEn, psel, penable, pwrite, rdErr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, periphIrq, supervisorIrq, pinIrq;
	logic        external_reset_pin, watchdog_reset_source;
	logic        precise_low_voltage_reset, stateHold, boostStandby, ctwIrq;
	logic [7:0]  subClkIn, subEnable, subClkOut;
	logic [2:0]  globalMode;
	logic [5:0]  fire;
	int          error_cnt, num_checks, cyc, k;
	// ==========================================
	// Instances
	pmm_power_mode_manager #(.NSUB(8), .SLEEP_CYCLES(8), .HIB_CYCLES(16)) dut (
		.clk(clk), .resetn(resetn), .clkEn(clkEn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periphIrq(periphIrq), .supervisorIrq(supervisorIrq),
		.pinIrq(pinIrq), .external_reset_pin(external_reset_pin),
		.watchdog_reset_source(watchdog_reset_source),
		.precise_low_voltage_reset(precise_low_voltage_reset),
		.subClkIn(subClkIn), .subEnable(subEnable), .subClkOut(subClkOut),
		.stateHold(stateHold), .boostStandby(boostStandby),
		.ctwIrq(ctwIrq), .globalMode(globalMode));
	pmm_wake_model src (
		.clk(clk), .resetn(resetn), .fire(fire), .periphIrq(periphIrq),
		.supervisorIrq(supervisorIrq), .pinIrq(pinIrq),
		.external_reset_pin(external_reset_pin),
		.watchdog_reset_source(watchdog_reset_source),
		.precise_low_voltage_reset(precise_low_voltage_reset),
		.subClkIn(subClkIn));
	// ==========================================
	// Tasks
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("Error pready exp 1 got %0h", pready);
		end
		rd = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Wait for a mode, bounded
	task automatic wait_mode(input logic [2:0] m);
		k = 0;
		while (globalMode !== m && k < 300) begin
			@(negedge clk);
			k++;
		end
		if (globalMode !== m) begin
			error_cnt++;
			$display("Error mode wait exp %0h got %0h", m, globalMode);
		end
	endtask : wait_mode
	// One-cycle request to the source model
	task automatic pulse(input logic [5:0] v);
		@(posedge clk);
		fire <= v;
		@(posedge clk);
		fire <= 6'h00;
	endtask : pulse
	// Length of the resume phase
	task automatic count_resume(input int ex);
		wait_mode(3'h4);
		k = 0;
		while (globalMode === 3'h4 && k < 100) begin
			@(negedge clk);
			k++;
		end
		`CHK("resume", ex, k)
	endtask : count_resume
	task automatic go_mode(input logic [31:0] m);
		apb(1'b1, `PMM_ADDR_MODE_REQ, m);
		wait_mode(m[2:0]);
	endtask : go_mode
	// ==========================================
	// Scenarios
	task automatic t_reset;
		`CHK("mode", 3'h0, globalMode)
		`CHK("enable", 8'hff, subEnable)
		`CHK("ready", 1'b1, pready)
		apb(1'b0, `PMM_ADDR_ACT_TPL, 32'h0);
		`CHK("act", 32'h000000ff, rd)
		apb(1'b0, `PMM_ADDR_ALT_TPL, 32'h0);
		`CHK("alt", 32'h000000fe, rd)
		apb(1'b0, `PMM_ADDR_WAKE_EN, 32'h0);
		`CHK("wake", 32'h0000000f, rd)
		apb(1'b0, `PMM_ADDR_CTW, 32'h0);
		`CHK("period", 32'h0000ffff, rd)
		apb(1'b0, 12'h020, 32'h0);
		`CHK("unmapped", 1'b1, rdErr)
	endtask : t_reset
	task automatic t_template;
		apb(1'b1, `PMM_ADDR_ACT_TPL, 32'h5a);
		repeat (3) @(negedge clk);
		`CHK("enable", 8'h5a, subEnable)
		`CHK("gated", subClkIn & 8'h5a, subClkOut)
	endtask : t_template
	task automatic t_alt;
		apb(1'b1, `PMM_ADDR_BOOST, 32'h1);
		go_mode(32'h1);
		repeat (2) @(negedge clk);
		`CHK("enable", 8'hfe, subEnable)
		`CHK("boost", 1'b0, boostStandby)
		pulse(6'h01);
		wait_mode(3'h0);
		repeat (2) @(negedge clk);
		`CHK("cpu", 8'h5b, subEnable)
		apb(1'b0, `PMM_ADDR_STATUS, 32'h0);
		`CHK("status", 32'h00000008, rd)
	endtask : t_alt
	task automatic t_sleep_ctw;
		apb(1'b1, `PMM_ADDR_CTW, 32'h14);
		@(posedge ctwIrq);
		@(negedge clk);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (ctwIrq !== 1'b1 && k < 100);
		`CHK("period", 21, k)
		go_mode(32'h2);
		`CHK("boost", 1'b1, boostStandby)
		count_resume(8);
		`CHK("mode", 3'h0, globalMode)
		apb(1'b1, `PMM_ADDR_CTW, 32'hffff);
	endtask : t_sleep_ctw
	task automatic t_masks;
		apb(1'b1, `PMM_ADDR_MODE_REQ, 32'h4);
		repeat (3) @(negedge clk);
		`CHK("mode", 3'h0, globalMode)
		apb(1'b1, `PMM_ADDR_WAKE_EN, 32'he);
		go_mode(32'h2);
		pulse(6'h01);
		repeat (12) @(negedge clk);
		`CHK("masked", 3'h2, globalMode)
		pulse(6'h02);
		wait_mode(3'h0);
		`CHK("mode", 3'h0, globalMode)
		apb(1'b1, `PMM_ADDR_WAKE_EN, 32'hf);
	endtask : t_masks
	task automatic t_hib;
		go_mode(32'h3);
		`CHK("hold", 1'b1, stateHold)
		`CHK("boost", 1'b0, boostStandby)
		pulse(6'h01);
		repeat (12) @(negedge clk);
		`CHK("mode", 3'h3, globalMode)
		pulse(6'h04);
		count_resume(16);
		`CHK("hold", 1'b0, stateHold)
		repeat (40) @(negedge clk);
	endtask : t_hib
	task automatic t_reset_src;
		for (int i = 3; i < 6; i++) begin
			go_mode(32'h2);
			pulse(6'h01 << i);
			wait_mode(3'h0);
			`CHK("wake", 3'h0, globalMode)
		end
	endtask : t_reset_src
	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// ==========================================
	// Clock, timeout and main sequence
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up;
		end
	end
	initial begin
		resetn = 1'b0;
		clkEn = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fire = 6'h00;
		error_cnt = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(negedge clk);
		t_reset;
		t_template;
		t_alt;
		t_sleep_ctw;
		t_masks;
		t_hib;
		t_reset_src;
		wrap_up;
	end
endmodule : pmm_power_mode_manager_bench
`default_nettype wire
